// ### common/dsc_pkg.sv
// Constants for the serial command and reference block
package dsc_pkg;
	localparam int         REF_W         = 16;
	localparam logic [15:0] REF_FULL     = 16'h4000;
	localparam int         REF_FULL_SH   = 14;
	localparam logic [15:0] REF_MAX_POS  = 16'h7FFF;
	localparam logic [15:0] REF_MIN_NEG  = 16'h8001;
	// Register offsets
	localparam logic [3:0] OFS_REF       = 4'h0;
	localparam logic [3:0] OFS_CTRL      = 4'h1;
	localparam logic [3:0] OFS_REF_MIN   = 4'h2;
	localparam logic [3:0] OFS_REF_MAX   = 4'h3;
	localparam logic [3:0] OFS_FRQ_LO    = 4'h4;
	localparam logic [3:0] OFS_FRQ_HI    = 4'h5;
	localparam logic [3:0] OFS_SRC       = 4'h6;
	localparam logic [3:0] OFS_ADDR      = 4'h7;
	localparam logic [3:0] OFS_BAUD      = 4'h8;
	localparam logic [3:0] OFS_SCALED    = 4'h9;
	localparam logic [3:0] OFS_OFREQ     = 4'hA;
	localparam logic [3:0] OFS_STATUS    = 4'hB;
	localparam logic [3:0] OFS_MEAS      = 4'hC;
	// Control word bits
	localparam int         CW_DCBRK      = 2;
	localparam int         CW_COAST      = 3;
	localparam int         CW_QSTOP      = 4;
	// Source field positions in the source register
	localparam int         SRC_COAST_LSB = 0;
	localparam int         SRC_QSTOP_LSB = 2;
	localparam int         SRC_DCBRK_LSB = 4;
	localparam int         N_CMD         = 3;
	typedef enum logic [1:0] {
		DSC_SRC_DIN,
		DSC_SRC_SER,
		DSC_SRC_AND,
		DSC_SRC_OR
	} dsc_src_e;
	localparam logic [5:0] SRC_RST       = 6'h3F;
	// Protocols and address bounds
	typedef enum logic [1:0] {
		DSC_PROT_NATIVE,
		DSC_PROT_BAS,
		DSC_PROT_RSV,
		DSC_PROT_MODBUS
	} dsc_prot_e;
	localparam logic [7:0] ADDR_RST      = 8'h01;
	localparam logic [7:0] ADDR_MAX_STD  = 8'hF7;
	localparam logic [7:0] ADDR_MAX_BAS  = 8'hFF;
	localparam logic [7:0] ADDR_MIN_ONE  = 8'h01;
	// Baud codes 0..5 mean 300..9600
	localparam logic [2:0] BAUD_300      = 3'h0;
	localparam logic [2:0] BAUD_9600     = 3'h5;
	localparam logic [2:0] BAUD_RST      = BAUD_9600;
	localparam logic [15:0] REF_MIN_RST  = 16'h0000;
	localparam logic [15:0] REF_MAX_RST  = 16'h0032;
	localparam logic [15:0] FRQ_LO_RST   = 16'h0000;
	localparam logic [15:0] FRQ_HI_RST   = 16'h0032;
	localparam logic [15:0] CTRL_RST     = 16'h0000;
endpackage

// ### hdl/dsc_core.sv
// Serial command source selection and reference scaling
`timescale 1ns/1ns
// Notes on behaviour
// - Serial speed reference is 16-bit, range 0 to +/-32767 meaning +/-200 percent.
// - Reference 0..16384 maps linearly from minimum to maximum reference.
// - Negative two's-complement reference reverses rotation; 0xE000 is minus 50 percent.
// - Present output frequency reported as 16-bit word, 0 to 32767 meaning 0 to 200 percent.
// - Reported frequency maps low..high output limit onto 0..16384.
// - Address ranges: native 0-247, automation 1-255, Modbus 1-247; default 1.
// - Address writes over the serial link are refused; panel only.
// - Baud codes 0..5 mean 300..9600 bit/s; default 9600.
// - Master must use the configured bit rate; no auto adaptation.
// - Baud setting is not writable over the serial port; panel only.
// - Each command has 2-bit source: input, serial, AND, OR; default OR.
// - Serial source acts on control-word bit only, ignoring the input.
// - Coast active low on input and bit 3 per source mode table.
// - Quick stop active low on input and bit 4, same four modes.
// - DC brake active low on input and bit 2, same four modes.
module dsc_core
	import dsc_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst_n,
	input  wire logic [3:0]         i_addr,
	input  wire logic [DATA_W-1:0]  i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	input  wire logic               i_panel_wr,
	input  wire logic [3:0]         i_panel_addr,
	input  wire logic [DATA_W-1:0]  i_panel_wdata,
	input  wire logic [1:0]         i_protocol,
	input  wire logic [DATA_W-1:0]  i_out_freq,
	input  wire logic               i_din_coast_n,
	input  wire logic               i_din_qstop_n,
	input  wire logic               i_din_dcbrk_n,
	output logic [DATA_W-1:0]       o_rdata,
	output logic                    o_coast,
	output logic                    o_qstop,
	output logic                    o_dcbrk,
	output logic                    o_reverse,
	output logic [DATA_W-1:0]       o_speed_ref,
	output logic [DATA_W-1:0]       o_freq_word,
	output logic [7:0]              o_station_addr,
	output logic [2:0]              o_baud_sel
);
	import dsc_pkg::*;

	logic [15:0] ref_word;
	logic [15:0] ctrl_word;
	logic [15:0] ref_min;
	logic [15:0] ref_max;
	logic [15:0] frq_lo;
	logic [15:0] frq_hi;
	logic [5:0]  src_sel;
	logic [7:0]  station;
	logic [2:0]  baud;
	logic        addr_reject;

	// Serial writes reach only the link-owned registers
	wire ser_wr_ref  = i_wr && (i_addr == OFS_REF);
	wire ser_wr_ctrl = i_wr && (i_addr == OFS_CTRL);
	wire ser_wr_lock = i_wr && ((i_addr == OFS_ADDR) || (i_addr == OFS_BAUD));
	wire pnl_wr_min  = i_panel_wr && (i_panel_addr == OFS_REF_MIN);
	wire pnl_wr_max  = i_panel_wr && (i_panel_addr == OFS_REF_MAX);
	wire pnl_wr_flo  = i_panel_wr && (i_panel_addr == OFS_FRQ_LO);
	wire pnl_wr_fhi  = i_panel_wr && (i_panel_addr == OFS_FRQ_HI);
	wire pnl_wr_src  = i_panel_wr && (i_panel_addr == OFS_SRC);
	wire pnl_wr_addr = i_panel_wr && (i_panel_addr == OFS_ADDR);
	wire pnl_wr_baud = i_panel_wr && (i_panel_addr == OFS_BAUD);

	// Address range depends on the active protocol
	wire [7:0] pnl_addr_v = i_panel_wdata[7:0];
	wire       addr_hi_ok = (i_protocol == DSC_PROT_BAS) ? 1'b1 : (pnl_addr_v <= ADDR_MAX_STD);
	wire       addr_lo_ok = (i_protocol == DSC_PROT_NATIVE) ? 1'b1 : (pnl_addr_v >= ADDR_MIN_ONE);
	wire       addr_ok    = addr_hi_ok && addr_lo_ok && (i_panel_wdata[15:8] == 8'h00)
		&& (i_protocol != DSC_PROT_RSV);
	wire [2:0] pnl_baud_v = i_panel_wdata[2:0];
	wire       baud_ok    = (pnl_baud_v <= BAUD_9600) && (i_panel_wdata[15:3] == 13'h0000);

	// A reference of -32768 is outside the range and is held back
	wire ref_ok = (i_wdata != 16'h8000);

	// Sign and magnitude of the reference
	wire        ref_neg = ref_word[15];
	wire [15:0] ref_mag = ref_neg ? (16'h0000 - ref_word) : ref_word;

	// Linear map: min + mag * (max - min) / 16384, magnitude up to 200 percent
	wire signed [17:0] ref_span  = $signed({2'b00, ref_max}) - $signed({2'b00, ref_min});
	wire signed [34:0] ref_prod  = $signed({1'b0, ref_mag}) * ref_span;
	wire signed [34:0] ref_quot  = ref_prod >>> REF_FULL_SH;
	wire signed [34:0] ref_sum   = ref_quot + $signed({19'h00000, ref_min});
	wire [15:0]        next_speed_ref = (ref_sum < 0) ? 16'h0000 :
		(ref_sum > $signed({19'h00000, 16'hFFFF})) ? 16'hFFFF : ref_sum[15:0];

	// Frequency back into the 16384-per-span word
	wire        frq_below = (i_out_freq <= frq_lo);
	wire [15:0] frq_span  = (frq_hi > frq_lo) ? (frq_hi - frq_lo) : 16'h0001;
	wire [15:0] frq_rel   = frq_below ? 16'h0000 : (i_out_freq - frq_lo);
	wire [29:0] frq_num   = {frq_rel, 14'h0000};
	wire [29:0] frq_quot  = frq_num / {14'h0000, frq_span};
	wire [15:0] next_freq_word = (frq_quot > {14'h0000, REF_MAX_POS}) ? REF_MAX_POS
		: frq_quot[15:0];

	// Per-command source combination, all active low
	wire [N_CMD-1:0] din_n = {i_din_dcbrk_n, i_din_qstop_n, i_din_coast_n};
	wire [N_CMD-1:0] ser_n = {ctrl_word[CW_DCBRK], ctrl_word[CW_QSTOP], ctrl_word[CW_COAST]};
	logic [N_CMD-1:0] next_cmd;
	genvar g;
	generate
		for (g = 0; g < N_CMD; g++) begin : g_cmd
			wire [1:0] mode = src_sel[2*g +: 2];
			// Active when chosen low; AND needs both low, OR needs either low
			assign next_cmd[g] =
				(mode == DSC_SRC_DIN) ? ~din_n[g] :
				(mode == DSC_SRC_SER) ? ~ser_n[g] :
				(mode == DSC_SRC_AND) ? (~din_n[g] & ~ser_n[g]) :
				(~din_n[g] | ~ser_n[g]);
		end
	endgenerate

	// Read decode
	wire [15:0] status_v = {9'h000, addr_reject, ref_neg, o_dcbrk, o_qstop, o_coast, 2'b00};
	wire [15:0] next_rdata =
		(i_addr == OFS_REF)     ? ref_word :
		(i_addr == OFS_CTRL)    ? ctrl_word :
		(i_addr == OFS_REF_MIN) ? ref_min :
		(i_addr == OFS_REF_MAX) ? ref_max :
		(i_addr == OFS_FRQ_LO)  ? frq_lo :
		(i_addr == OFS_FRQ_HI)  ? frq_hi :
		(i_addr == OFS_SRC)     ? {10'h000, src_sel} :
		(i_addr == OFS_ADDR)    ? {8'h00, station} :
		(i_addr == OFS_BAUD)    ? {13'h0000, baud} :
		(i_addr == OFS_SCALED)  ? o_speed_ref :
		(i_addr == OFS_OFREQ)   ? o_freq_word :
		(i_addr == OFS_STATUS)  ? status_v :
		(i_addr == OFS_MEAS)    ? i_out_freq : 16'h0000;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ref_word  <= 16'h0000;
			ctrl_word <= CTRL_RST;
		end else begin
			if (ser_wr_ref && ref_ok)
				ref_word <= i_wdata;
			if (ser_wr_ctrl)
				ctrl_word <= i_wdata;
		end
	end

	// Settings owned by the panel only; the link can never reach them
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ref_min <= REF_MIN_RST;
			ref_max <= REF_MAX_RST;
			frq_lo  <= FRQ_LO_RST;
			frq_hi  <= FRQ_HI_RST;
			src_sel <= SRC_RST;
		end else begin
			if (pnl_wr_min) ref_min <= i_panel_wdata;
			if (pnl_wr_max) ref_max <= i_panel_wdata;
			if (pnl_wr_flo) frq_lo <= i_panel_wdata;
			if (pnl_wr_fhi) frq_hi <= i_panel_wdata;
			if (pnl_wr_src) src_sel <= i_panel_wdata[5:0];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			station     <= ADDR_RST;
			baud        <= BAUD_RST;
			addr_reject <= 1'b0;
		end else begin
			if (pnl_wr_addr && addr_ok)
				station <= pnl_addr_v;
			if (pnl_wr_baud && baud_ok)
				baud <= pnl_baud_v;
			// Sticky flag: a link write to the address or baud register sets it, a read of status clears it
			if (ser_wr_lock)
				addr_reject <= 1'b1;
			else if (i_rd && (i_addr == OFS_STATUS))
				addr_reject <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_rdata        <= 16'h0000;
			o_coast        <= 1'b0;
			o_qstop        <= 1'b0;
			o_dcbrk        <= 1'b0;
			o_reverse      <= 1'b0;
			o_speed_ref    <= 16'h0000;
			o_freq_word    <= 16'h0000;
			o_station_addr <= ADDR_RST;
			o_baud_sel     <= BAUD_RST;
		end else begin
			o_rdata        <= i_rd ? next_rdata : 16'h0000;
			o_coast        <= next_cmd[0];
			o_qstop        <= next_cmd[1];
			o_dcbrk        <= next_cmd[2];
			o_reverse      <= ref_neg;
			o_speed_ref    <= next_speed_ref;
			o_freq_word    <= next_freq_word;
			o_station_addr <= station;
			o_baud_sel     <= baud;
		end
	end

	// Checks
	a_coast_or_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[1:0] == DSC_SRC_OR) && !(i_din_coast_n && ctrl_word[CW_COAST])
		|=> o_coast) else $error("coast missing in OR mode");
	a_coast_and_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[1:0] == DSC_SRC_AND) && i_din_coast_n |=> !o_coast)
		else $error("coast in AND mode with input high");
	a_qstop_ser_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[3:2] == DSC_SRC_SER) |=> (o_qstop == !$past(ctrl_word[CW_QSTOP])))
		else $error("quick stop not from control bit");
	a_dcbrk_din_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[5:4] == DSC_SRC_DIN) |=> (o_dcbrk == !$past(i_din_dcbrk_n)))
		else $error("dc brake not from input");
	a_addr_locked: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		ser_wr_lock && !i_panel_wr |=> $stable(station) && $stable(baud) && addr_reject)
		else $error("locked setting changed by link");
	a_addr_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_protocol == DSC_PROT_MODBUS) |-> (station != 8'h00) || $past(i_protocol)
		!= DSC_PROT_MODBUS || !$changed(station)) else $error("address out of range");
	a_baud_range: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		baud <= BAUD_9600) else $error("baud code out of range");
	a_reverse_sign: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		ser_wr_ref && ref_ok ##1 1'b1 |=> o_reverse == $past(ref_word[15]))
		else $error("direction does not follow sign");
	a_read_timing: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!i_rd |=> o_rdata == 16'h0000) else $error("read data outside answer cycle");
	// Coast in every source mode
	a_coast_din_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[1:0] == DSC_SRC_DIN) |=> (o_coast == !$past(i_din_coast_n)))
		else $error("coast not from input");
	a_coast_ser_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[1:0] == DSC_SRC_SER) |=> (o_coast == !$past(ctrl_word[CW_COAST])))
		else $error("coast not from control bit");
	a_coast_and_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[1:0] == DSC_SRC_AND) && !i_din_coast_n && !ctrl_word[CW_COAST] |=> o_coast)
		else $error("coast missing in AND mode");
	a_coast_or_high: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[1:0] == DSC_SRC_OR) && i_din_coast_n && ctrl_word[CW_COAST] |=> !o_coast)
		else $error("coast in OR mode with both high");
	// Quick stop in the remaining modes
	a_qstop_din_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[3:2] == DSC_SRC_DIN) |=> (o_qstop == !$past(i_din_qstop_n)))
		else $error("quick stop not from input");
	a_qstop_and_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[3:2] == DSC_SRC_AND) |=> (o_qstop == $past(!i_din_qstop_n && !ctrl_word[CW_QSTOP])))
		else $error("quick stop wrong in AND mode");
	a_qstop_or_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[3:2] == DSC_SRC_OR) |=> (o_qstop == $past(!i_din_qstop_n || !ctrl_word[CW_QSTOP])))
		else $error("quick stop wrong in OR mode");
	// DC brake in the remaining modes
	a_dcbrk_ser_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[5:4] == DSC_SRC_SER) |=> (o_dcbrk == !$past(ctrl_word[CW_DCBRK])))
		else $error("dc brake not from control bit");
	a_dcbrk_and_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[5:4] == DSC_SRC_AND) |=> (o_dcbrk == $past(!i_din_dcbrk_n && !ctrl_word[CW_DCBRK])))
		else $error("dc brake wrong in AND mode");
	a_dcbrk_or_mode: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[5:4] == DSC_SRC_OR) |=> (o_dcbrk == $past(!i_din_dcbrk_n || !ctrl_word[CW_DCBRK])))
		else $error("dc brake wrong in OR mode");
	// Link-owned registers take only legal words
	a_ref_refused: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		ser_wr_ref && !ref_ok |=> $stable(ref_word))
		else $error("out of range reference taken");
	a_ref_taken: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		ser_wr_ref && ref_ok |=> ref_word == $past(i_wdata))
		else $error("reference write lost");
	a_ctrl_taken: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		ser_wr_ctrl |=> ctrl_word == $past(i_wdata))
		else $error("control word write lost");
	a_reverse_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		1'b1 |=> o_reverse == $past(ref_neg))
		else $error("direction output stale");
	// Scaling end points; the middle is left to the bench
	a_speed_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(ref_word == 16'h0000) |=> o_speed_ref == $past(ref_min))
		else $error("zero reference not at minimum");
	a_speed_full: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(ref_word == REF_FULL) && (ref_max >= ref_min) |=> o_speed_ref == $past(ref_max))
		else $error("full reference not at maximum");
	a_freq_below: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(i_out_freq <= frq_lo) |=> o_freq_word == 16'h0000)
		else $error("frequency below low limit not zero");
	a_freq_full: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(frq_hi > frq_lo) && (i_out_freq == frq_hi) |=> o_freq_word == REF_FULL)
		else $error("frequency at high limit not full scale");
	a_freq_limit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		1'b1 |=> o_freq_word <= REF_MAX_POS)
		else $error("frequency word above positive range");
	// Panel-only settings
	a_reject_set: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		ser_wr_lock |=> addr_reject)
		else $error("refused write not flagged");
	a_baud_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!pnl_wr_baud |=> $stable(baud))
		else $error("baud changed without panel write");
	a_station_stable: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		!pnl_wr_addr |=> $stable(station))
		else $error("address changed without panel write");
	a_station_copy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		1'b1 |=> o_station_addr == $past(station))
		else $error("address output stale");
	a_baud_copy: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		1'b1 |=> o_baud_sel == $past(baud))
		else $error("baud output stale");
	a_station_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		i_rd && (i_addr == OFS_ADDR) |=> o_rdata == {8'h00, $past(station)})
		else $error("address read back wrong");
	a_src_accept: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		pnl_wr_src |=> src_sel == $past(i_panel_wdata[5:0]))
		else $error("source setting write lost");
	// Covers for the main scenarios
	c_coast_or: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[1:0] == DSC_SRC_OR) ##1 o_coast);
	c_reverse: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_reverse);
	c_lock_hit: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) ser_wr_lock);
	c_qstop_and: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		(src_sel[3:2] == DSC_SRC_AND) ##1 o_qstop);
endmodule

// ### tb/drive_serial_command_select_bench.sv
// Self-checking bench for the serial command and reference block
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module drive_serial_command_select_bench;
	import dsc_pkg::*;
	logic        i_clk_sys = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [3:0]  i_addr;
	logic [15:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic        i_panel_wr = 1'b0;
	logic [3:0]  i_panel_addr = 4'h0;
	logic [15:0] i_panel_wdata = 16'h0000;
	logic [1:0]  i_protocol = 2'h0;
	logic [15:0] i_out_freq = 16'h0000;
	logic        i_din_n = 1'b1;
	logic [15:0] o_rdata;
	logic        o_coast, o_qstop, o_dcbrk, o_reverse;
	logic [15:0] o_speed_ref, o_freq_word;
	logic [7:0]  o_station_addr;
	logic [2:0]  o_baud_sel;
	int          errors = 0;
	int          n_compared = 0;
	logic [15:0] rv;
	logic        e;
	logic [7:0]  ea;
	logic [1:0]  pa [6] = '{2'h0, 2'h3, 2'h3, 2'h3, 2'h1, 2'h1};
	logic [7:0]  va [6] = '{8'h00, 8'h00, 8'hF7, 8'hF8, 8'h00, 8'hFF};
	logic        ok [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
	logic [15:0] rst_tab [7] = '{16'h0000, 16'h0032, 16'h0000, 16'h0032, 16'h003F,
		16'h0001, 16'h0005};
	always #5 i_clk_sys = ~i_clk_sys;
	dsc_link_master LM (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .o_addr(i_addr),
		.o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));
	dsc_core DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_panel_wr(i_panel_wr),
		.i_panel_addr(i_panel_addr), .i_panel_wdata(i_panel_wdata),
		.i_protocol(i_protocol), .i_out_freq(i_out_freq), .i_din_coast_n(i_din_n),
		.i_din_qstop_n(i_din_n), .i_din_dcbrk_n(i_din_n), .o_rdata(o_rdata),
		.o_coast(o_coast), .o_qstop(o_qstop), .o_dcbrk(o_dcbrk), .o_reverse(o_reverse),
		.o_speed_ref(o_speed_ref), .o_freq_word(o_freq_word),
		.o_station_addr(o_station_addr), .o_baud_sel(o_baud_sel));
	function automatic logic act(input logic [1:0] m, input logic d, input logic w);
		case (m)
			2'h0: act = !d;
			2'h1: act = !w;
			2'h2: act = !d && !w;
			default: act = !d || !w;
		endcase
	endfunction
	task automatic panel(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_panel_wr <= 1'b1;
		i_panel_addr <= a;
		i_panel_wdata <= d;
		@(posedge i_clk_sys);
		i_panel_wr <= 1'b0;
	endtask
	task automatic settle();
		repeat (3) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Watchdog bounds the whole run, a stuck sequence counts as a mismatch
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		#1;
		`CHK(o_station_addr, 8'h01)
		`CHK(o_baud_sel, 3'h5)
		for (int i = 0; i < 7; i++) begin
			LM.read(OFS_REF_MIN + 4'(i), rv);
			`CHK(rv, rst_tab[i])
		end
		LM.read(4'hE, rv);
		`CHK(rv, 16'h0000)
		// Every source mode against every input and control-bit pair
		for (int m = 0; m < 4; m++) begin
			panel(OFS_SRC, {10'h000, 2'(m), 2'(m), 2'(m)});
			for (int c = 0; c < 4; c++) begin
				i_din_n <= c[1];
				LM.write(OFS_CTRL, {11'h000, {3{c[0]}}, 2'h0});
				settle();
				e = act(2'(m), c[1], c[0]);
				`CHK(o_coast, e)
				`CHK(o_qstop, e)
				`CHK(o_dcbrk, e)
				LM.read(OFS_STATUS, rv);
				`CHK(rv[4:2], {3{e}})
			end
		end
		LM.write(OFS_REF, 16'h4000);
		settle();
		`CHK(o_speed_ref, 16'h0032)
		LM.write(OFS_REF, 16'h7FFF);
		settle();
		`CHK(o_speed_ref, 16'h0063)
		LM.write(OFS_REF, 16'hE000);
		settle();
		`CHK(o_reverse, 1'b1)
		`CHK(o_speed_ref, 16'h0019)
		LM.write(OFS_REF, 16'h8000);
		settle();
		`CHK(o_speed_ref, 16'h0019)
		panel(OFS_REF_MIN, 16'h0010);
		panel(OFS_REF_MAX, 16'h4010);
		LM.write(OFS_REF, 16'h2000);
		settle();
		`CHK(o_reverse, 1'b0)
		`CHK(o_speed_ref, 16'h2010)
		i_out_freq <= 16'h0019;
		settle();
		`CHK(o_freq_word, 16'h2000)
		i_out_freq <= 16'h0064;
		settle();
		`CHK(o_freq_word, 16'h7FFF)
		panel(OFS_FRQ_LO, 16'h0010);
		i_out_freq <= 16'h0005;
		settle();
		`CHK(o_freq_word, 16'h0000)
		LM.read(OFS_SCALED, rv);
		`CHK(rv, 16'h2010)
		LM.read(OFS_OFREQ, rv);
		`CHK(rv, 16'h0000)
		LM.read(OFS_MEAS, rv);
		`CHK(rv, 16'h0005)
		ea = 8'h01;
		for (int i = 0; i < 6; i++) begin
			i_protocol <= pa[i];
			panel(OFS_ADDR, {8'h00, va[i]});
			if (ok[i])
				ea = va[i];
			settle();
			`CHK(o_station_addr, ea)
		end
		LM.write(OFS_ADDR, 16'h0022);
		settle();
		`CHK(o_station_addr, ea)
		LM.read(OFS_STATUS, rv);
		`CHK(rv[6], 1'b1)
		LM.read(OFS_STATUS, rv);
		`CHK(rv[6], 1'b0)
		panel(OFS_BAUD, 16'h0006);
		settle();
		`CHK(o_baud_sel, 3'h5)
		panel(OFS_BAUD, 16'h0000);
		LM.write(OFS_BAUD, 16'h0003);
		settle();
		`CHK(o_baud_sel, 3'h0)
		LM.read(OFS_STATUS, rv);
		`CHK(rv[6], 1'b1)
		report_and_stop();
	end
endmodule

// ### tb/dsc_link_master.sv
// Serial link master model driving the register port of the block
`timescale 1ns/1ns
module dsc_link_master (
	input  wire logic        i_clk_sys,
	input  wire logic [15:0] i_rdata,
	output logic [3:0]       o_addr,
	output logic [15:0]      o_wdata,
	output logic             o_wr,
	output logic             o_rd
);
	initial begin
		o_addr = 4'h0;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// Whole 16-bit words only; negative values arrive already in two's complement
	task automatic write(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk_sys);
		o_wr <= 1'b0;
		// Inverted idle data exposes a slave that samples outside the strobe
		o_wdata <= ~d;
	endtask
	task automatic read(input logic [3:0] a, output logic [15:0] d);
		@(posedge i_clk_sys);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk_sys);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask
endmodule
